// ### rtl/hprm_params.svh
// holds offsets, field positions, reset values and timing counts of the halt/power/misc bank
// assumes inclusion by the bank module and the bench only
`ifndef HPRM_PARAMS_SVH
`define HPRM_PARAMS_SVH
`define HPRM_ADDR_HALT 32'hF7000100
`define HPRM_ADDR_RST 32'hF7000140
`define HPRM_ADDR_MISC 32'hF7000180
`define HPRM_ADDR_RMODE 32'hF7800000
`define HPRM_HALT_BRK_BIT 6
`define HPRM_HALT_PMB_BIT 5
`define HPRM_HALT_PMA_BIT 4
`define HPRM_HALT_LDC_BIT 3
`define HPRM_HALT_SEC_BIT 2
`define HPRM_HALT_NH_BIT 1
`define HPRM_MISC_FLT_BIT 2
`define HPRM_MISC_RSVD 5'h1F
`define HPRM_MISC_FLT_RST 1'h1
`define HPRM_MISC_EXP_RST 2'h3
`define HPRM_RST_CYCLES 10'h200
`endif

// ### rtl/hprm_pkg.sv
// holds the types of the halt/power/misc bank
// assumes the params header sits beside it
package hprm_pkg;
   typedef enum logic [1:0] {
      HPRM_EXP_MAIN,
      HPRM_EXP_RIGHT,
      HPRM_EXP_LEFT,
      HPRM_EXP_LOOP
   } hprm_exp_t;
   typedef struct packed {
      logic sel;
      logic wr;
      logic [31:0] addr;
      logic [7:0] wdata;
   } hprm_bus_t;
   typedef struct packed {
      logic pmodSecondGood;
      logic pmodFirstGood;
      logic diskConvGood;
      logic secureN;
   } hprm_pwr_t;
endpackage : hprm_pkg

// ### rtl/hprm_regs.sv
// holds the halt/power/misc register bank on the local byte bus
// assumes bus strobes and node state come from mclk logic; status pins are asynchronous
//
// Contract
// - break char sets sticky halt bit 6
// - bit5 shows second power module good
// - bit4 shows first power module good
// - bit3 shows all disk converters good
// - bit2 shows inverted secure pin
// - secure blocks console break halts
// - bit1 mirrors node halt bit
// - halt bits 7 and 0 read zero
// - reset register write pulses reset 512 cycles
// - misc bits 7:3 read ones, unwritable
// - misc bit2 drives backplane fault
// - fault bit leaves self test passed alone
// - expander select steers supply serial lines
// - disconnect write sets force ignore
// - bank writes need no backplane transaction
// - console select picks break port
`include "hprm_params.svh"
module hprm_regs (
   input wire logic mclk,
   input wire logic reset,
   input wire hprm_pkg::hprm_bus_t bus,
   output logic [7:0] rdata,
   input wire logic [3:0] breakSeen,
   input wire logic [1:0] consoleSelect,
   input wire logic haltEnable,
   input wire logic nodeHalt,
   input wire hprm_pkg::hprm_pwr_t pwrPins,
   input wire logic selfTestIn,
   output logic selfTestPassed,
   output logic breakHalt,
   output logic backplaneReset,
   output logic backplaneFault,
   output logic forceIgnore,
   output logic [1:0] expanderSelect,
   input wire logic psTx,
   output logic psRx,
   input wire logic [2:0] cabinetRx,
   output logic [2:0] cabinetTx
);
   import hprm_pkg::*;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   hprm_pwr_t pwrMeta_q, pwrSync_q;
   logic [3:0] brkMeta_q, brkSync_q;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pwrMeta_q <= '0;
         pwrSync_q <= '0;
         brkMeta_q <= 4'h0;
         brkSync_q <= 4'h0;
      end else begin
         pwrMeta_q <= pwrPins;
         pwrSync_q <= pwrMeta_q;
         brkMeta_q <= breakSeen;
         brkSync_q <= brkMeta_q;
      end
   end

   // ************************************************************
   // address decode
   // ************************************************************
   // bank writes complete locally, no backplane cycle issued
   logic wrHalt, wrRst, wrMisc, wrRmode;
   assign wrHalt = bus.sel && bus.wr && (bus.addr == `HPRM_ADDR_HALT);
   assign wrRst = bus.sel && bus.wr && (bus.addr == `HPRM_ADDR_RST);
   assign wrMisc = bus.sel && bus.wr && (bus.addr == `HPRM_ADDR_MISC);
   assign wrRmode = bus.sel && bus.wr && (bus.addr == `HPRM_ADDR_RMODE);

   // ************************************************************
   // console break halt flag
   // ************************************************************
   logic brkEvent, brkFlag_q, secure;
   assign secure = ~pwrSync_q.secureN;
   assign brkEvent = brkSync_q[consoleSelect];
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         brkFlag_q <= 1'b0;
      end else if (brkEvent) begin
         brkFlag_q <= 1'b1;
      end else if (wrHalt && bus.wdata[`HPRM_HALT_BRK_BIT]) begin
         brkFlag_q <= 1'b0;
      end
   end
   assign breakHalt = brkFlag_q && haltEnable && !secure;

   // ************************************************************
   // backplane reset pulse
   // ************************************************************
   logic [9:0] rstCnt_q;
   logic rstActive_q;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rstCnt_q <= 10'h000;
         rstActive_q <= 1'b0;
      end else if (wrRst) begin
         rstCnt_q <= 10'h000;
         rstActive_q <= 1'b1;
      end else if (rstActive_q) begin
         if (rstCnt_q == `HPRM_RST_CYCLES - 10'h001) begin
            rstActive_q <= 1'b0;
            rstCnt_q <= 10'h000;
         end else begin
            rstCnt_q <= rstCnt_q + 10'h001;
         end
      end
   end
   assign backplaneReset = rstActive_q;

   // ************************************************************
   // misc control and disconnect
   // ************************************************************
   logic fault_q, ignore_q;
   logic [1:0] exp_q;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         fault_q <= `HPRM_MISC_FLT_RST;
         exp_q <= `HPRM_MISC_EXP_RST;
      end else if (wrMisc) begin
         fault_q <= bus.wdata[`HPRM_MISC_FLT_BIT];
         exp_q <= bus.wdata[1:0];
      end
   end
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ignore_q <= 1'b0;
      end else if (wrRmode) begin
         ignore_q <= 1'b1;
      end
   end
   assign forceIgnore = ignore_q;
   assign backplaneFault = fault_q;
   assign selfTestPassed = selfTestIn;
   assign expanderSelect = exp_q;

   // supply serial steering
   always_comb begin
      cabinetTx = 3'h0;
      psRx = 1'b1;
      case (hprm_exp_t'(exp_q))
         HPRM_EXP_MAIN: begin
            cabinetTx[0] = psTx;
            psRx = cabinetRx[0];
         end
         HPRM_EXP_RIGHT: begin
            cabinetTx[1] = psTx;
            psRx = cabinetRx[1];
         end
         HPRM_EXP_LEFT: begin
            cabinetTx[2] = psTx;
            psRx = cabinetRx[2];
         end
         HPRM_EXP_LOOP: begin
            psRx = psTx;
         end
         default: begin
            psRx = 1'b1;
         end
      endcase
   end

   // ************************************************************
   // read data
   // ************************************************************
   logic [7:0] haltView, miscView;
   always_comb begin
      haltView = 8'h00;
      haltView[`HPRM_HALT_BRK_BIT] = brkFlag_q;
      haltView[`HPRM_HALT_PMB_BIT] = pwrSync_q.pmodSecondGood;
      haltView[`HPRM_HALT_PMA_BIT] = pwrSync_q.pmodFirstGood;
      haltView[`HPRM_HALT_LDC_BIT] = pwrSync_q.diskConvGood;
      haltView[`HPRM_HALT_SEC_BIT] = secure;
      haltView[`HPRM_HALT_NH_BIT] = nodeHalt;
      miscView = {`HPRM_MISC_RSVD, fault_q, exp_q};
   end
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rdata <= 8'h00;
      end else if (bus.sel && !bus.wr) begin
         case (bus.addr)
            `HPRM_ADDR_HALT: rdata <= haltView;
            `HPRM_ADDR_MISC: rdata <= miscView;
            default: rdata <= 8'h00;
         endcase
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   brk_set_a: assert property (@(posedge mclk) disable iff (reset)
      brkEvent |=> brkFlag_q) else $error("break flag not set");
   brk_clr_a: assert property (@(posedge mclk) disable iff (reset)
      (brkFlag_q && !brkEvent && !(wrHalt && bus.wdata[6])) |=> brkFlag_q)
      else $error("break flag lost");
   sec_block_a: assert property (@(posedge mclk) disable iff (reset)
      secure |-> !breakHalt) else $error("halt while secure");
   rst_start_a: assert property (@(posedge mclk) disable iff (reset)
      wrRst |=> backplaneReset && rstCnt_q == 10'h000) else $error("reset not started");
   rst_end_a: assert property (@(posedge mclk) disable iff (reset)
      (rstActive_q && rstCnt_q == 10'h1FF && !wrRst) |=> !backplaneReset)
      else $error("reset pulse overran");
   ign_hold_a: assert property (@(posedge mclk) disable iff (reset)
      wrRmode |=> forceIgnore [*2]) else $error("ignore not held");
   misc_rsvd_a: assert property (@(posedge mclk) disable iff (reset)
      (bus.sel && !bus.wr && bus.addr == `HPRM_ADDR_MISC) |=> rdata[7:3] == 5'h1F)
      else $error("misc reserved bits");
   halt_rsvd_a: assert property (@(posedge mclk) disable iff (reset)
      (bus.sel && !bus.wr && bus.addr == `HPRM_ADDR_HALT) |=> !rdata[7] && !rdata[0])
      else $error("halt reserved bits");
   fault_wr_a: assert property (@(posedge mclk) disable iff (reset)
      wrMisc |=> backplaneFault == $past(bus.wdata[2])) else $error("fault bit write");

   // ************************************************************
   // reset pulse length watch
   // ************************************************************
   // counts pulse cycles, a rewrite starts again at one
   logic [10:0] rstSeen_q;
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rstSeen_q <= 11'h000;
      end else if (wrRst) begin
         rstSeen_q <= 11'h001;
      end else if (backplaneReset) begin
         rstSeen_q <= rstSeen_q + 11'h001;
      end else begin
         rstSeen_q <= 11'h000;
      end
   end
   rst_len_a: assert property (@(posedge mclk) disable iff (reset)
      $fell(backplaneReset) |-> rstSeen_q == 11'(`HPRM_RST_CYCLES) + 11'h001)
      else $error("reset pulse length");
   rst_cap_a: assert property (@(posedge mclk) disable iff (reset)
      backplaneReset |-> rstSeen_q <= 11'(`HPRM_RST_CYCLES))
      else $error("reset pulse too long");

   // ************************************************************
   // status view checks
   // ************************************************************
   pmb_view_a: assert property (@(posedge mclk) disable iff (reset)
      haltView[`HPRM_HALT_PMB_BIT] == pwrSync_q.pmodSecondGood)
      else $error("second module view");
   pma_view_a: assert property (@(posedge mclk) disable iff (reset)
      haltView[`HPRM_HALT_PMA_BIT] == pwrSync_q.pmodFirstGood)
      else $error("first module view");
   ldc_view_a: assert property (@(posedge mclk) disable iff (reset)
      haltView[`HPRM_HALT_LDC_BIT] == pwrSync_q.diskConvGood)
      else $error("disk converter view");
   sec_view_a: assert property (@(posedge mclk) disable iff (reset)
      haltView[`HPRM_HALT_SEC_BIT] == !pwrSync_q.secureN)
      else $error("secure view");
   nh_view_a: assert property (@(posedge mclk) disable iff (reset)
      haltView[`HPRM_HALT_NH_BIT] == nodeHalt)
      else $error("node halt view");
   brk_view_a: assert property (@(posedge mclk) disable iff (reset)
      haltView[`HPRM_HALT_BRK_BIT] == brkFlag_q)
      else $error("break flag view");
   halt_rd_a: assert property (@(posedge mclk) disable iff (reset)
      (bus.sel && !bus.wr && bus.addr == `HPRM_ADDR_HALT) |=> rdata == $past(haltView))
      else $error("halt read data");
   misc_rd_a: assert property (@(posedge mclk) disable iff (reset)
      (bus.sel && !bus.wr && bus.addr == `HPRM_ADDR_MISC) |=> rdata == $past(miscView))
      else $error("misc read data");
   unmap_rd_a: assert property (@(posedge mclk) disable iff (reset)
      (bus.sel && !bus.wr && bus.addr != `HPRM_ADDR_HALT && bus.addr != `HPRM_ADDR_MISC)
      |=> rdata == 8'h00) else $error("unmapped read data");
   rd_hold_a: assert property (@(posedge mclk) disable iff (reset)
      !(bus.sel && !bus.wr) |=> $stable(rdata))
      else $error("read data moved");
   wr_onehot_a: assert property (@(posedge mclk) disable iff (reset)
      $onehot0({wrHalt, wrRst, wrMisc, wrRmode}))
      else $error("write decode overlap");
   pwr_sync_a: assert property (@(posedge mclk) disable iff (reset)
      pwrSync_q == $past(pwrMeta_q))
      else $error("power sync stage");
   brk_sync_a: assert property (@(posedge mclk) disable iff (reset)
      brkSync_q == $past(brkMeta_q))
      else $error("break sync stage");

   // ************************************************************
   // control checks
   // ************************************************************
   exp_wr_a: assert property (@(posedge mclk) disable iff (reset)
      wrMisc |=> expanderSelect == $past(bus.wdata[1:0]))
      else $error("expander select write");
   misc_hold_a: assert property (@(posedge mclk) disable iff (reset)
      !wrMisc |=> $stable(backplaneFault) && $stable(expanderSelect))
      else $error("misc changed unwritten");
   fault_out_a: assert property (@(posedge mclk) disable iff (reset)
      backplaneFault == fault_q)
      else $error("fault output");
   ign_stick_a: assert property (@(posedge mclk) disable iff (reset)
      forceIgnore |=> forceIgnore)
      else $error("ignore dropped");
   ign_src_a: assert property (@(posedge mclk) disable iff (reset)
      (!forceIgnore && !wrRmode) |=> !forceIgnore)
      else $error("ignore without write");
   ign_out_a: assert property (@(posedge mclk) disable iff (reset)
      forceIgnore == ignore_q)
      else $error("ignore output");
   rst_src_a: assert property (@(posedge mclk) disable iff (reset)
      (!backplaneReset && !wrRst) |=> !backplaneReset)
      else $error("reset without write");
   rst_cnt_a: assert property (@(posedge mclk) disable iff (reset)
      (rstActive_q && !wrRst && rstCnt_q != 10'h1FF) |=> rstCnt_q == 10'($past(rstCnt_q) + 10'h001))
      else $error("reset count step");
   rst_idle_a: assert property (@(posedge mclk) disable iff (reset)
      !rstActive_q |-> rstCnt_q == 10'h000)
      else $error("reset count idle");
   brk_need_a: assert property (@(posedge mclk) disable iff (reset)
      (!brkFlag_q && !brkEvent) |=> !brkFlag_q)
      else $error("break flag without event");
   brk_w1c_a: assert property (@(posedge mclk) disable iff (reset)
      (brkFlag_q && !brkEvent && wrHalt && bus.wdata[`HPRM_HALT_BRK_BIT]) |=> !brkFlag_q)
      else $error("break flag not cleared");
   halt_en_a: assert property (@(posedge mclk) disable iff (reset)
      !haltEnable |-> !breakHalt)
      else $error("halt while disabled");
   brk_halt_a: assert property (@(posedge mclk) disable iff (reset)
      (brkFlag_q && haltEnable && !secure) |-> breakHalt)
      else $error("break halt missing");
   stp_pass_a: assert property (@(posedge mclk) disable iff (reset)
      selfTestPassed == selfTestIn)
      else $error("self test passed output");
   ps_main_a: assert property (@(posedge mclk) disable iff (reset)
      (exp_q == 2'h0) |-> cabinetTx == {2'b00, psTx} && psRx == cabinetRx[0])
      else $error("main cabinet steering");
   ps_right_a: assert property (@(posedge mclk) disable iff (reset)
      (exp_q == 2'h1) |-> cabinetTx == {1'b0, psTx, 1'b0} && psRx == cabinetRx[1])
      else $error("right cabinet steering");
   ps_left_a: assert property (@(posedge mclk) disable iff (reset)
      (exp_q == 2'h2) |-> cabinetTx == {psTx, 2'b00} && psRx == cabinetRx[2])
      else $error("left cabinet steering");
   ps_loop_a: assert property (@(posedge mclk) disable iff (reset)
      (exp_q == 2'h3) |-> cabinetTx == 3'h0 && psRx == psTx)
      else $error("loopback steering");
endmodule : hprm_regs

// ### dv/hprm_cab_model.sv
// holds a behavioural model of the three cabinet power-supply links
// assumes each cabinet answers on its receive line with the inverse of what it hears
module hprm_cab_model (
   input wire logic [2:0] cabinetTx,
   output logic [2:0] cabinetRx
);
   timeunit 1ns;
   timeprecision 100ps;
   // inversion tells a cabinet echo apart from loopback
   assign cabinetRx = ~cabinetTx;
endmodule : hprm_cab_model

// ### dv/tb_top.sv
// holds the self-checking bench of the halt/power/misc bank
// assumes the bank package, the params header and the cabinet model
`include "hprm_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import hprm_pkg::*;
   logic mclk, reset, haltEnable, nodeHalt, selfTestIn, psTx, psRx;
   logic selfTestPassed, breakHalt, backplaneReset, backplaneFault, forceIgnore;
   logic [3:0] breakSeen;
   logic [1:0] consoleSelect, expanderSelect;
   logic [7:0] rdata;
   logic [2:0] cabinetRx, cabinetTx;
   hprm_bus_t bus;
   hprm_pwr_t pwrPins;
   int error_cnt, checks_done, n;
   hprm_regs hprm_regs_inst (.mclk(mclk), .reset(reset), .bus(bus), .rdata(rdata),
      .breakSeen(breakSeen), .consoleSelect(consoleSelect), .haltEnable(haltEnable),
      .nodeHalt(nodeHalt), .pwrPins(pwrPins), .selfTestIn(selfTestIn),
      .selfTestPassed(selfTestPassed), .breakHalt(breakHalt),
      .backplaneReset(backplaneReset), .backplaneFault(backplaneFault),
      .forceIgnore(forceIgnore), .expanderSelect(expanderSelect), .psTx(psTx),
      .psRx(psRx), .cabinetRx(cabinetRx), .cabinetTx(cabinetTx));
   hprm_cab_model hprm_cab_model_inst (.cabinetTx(cabinetTx), .cabinetRx(cabinetRx));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   // ****************
   // access tasks
   // ****************
   task results;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results
   task chk(input string what, input logic [15:0] seen, input logic [15:0] expv);
      checks_done++;
      if (seen !== expv) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, expv, seen);
      end
   endtask : chk
   task wr(input logic [31:0] a, input logic [7:0] d);
      @(negedge mclk);
      bus = '{sel: 1'b1, wr: 1'b1, addr: a, wdata: d};
      @(negedge mclk);
      bus.sel = 1'b0;
   endtask : wr
   task rd(input logic [31:0] a, input logic [7:0] expv, input string what);
      @(negedge mclk);
      bus = '{sel: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
      @(negedge mclk);
      bus.sel = 1'b0;
      @(negedge mclk);
      chk(what, {8'h00, rdata}, {8'h00, expv});
   endtask : rd
   task pulse_len(output int len);
      len = 0;
      while (backplaneReset === 1'b1 && len < 2000) begin
         len++;
         @(negedge mclk);
      end
      if (len == 2000) begin
         error_cnt++;
         results();
      end
   endtask : pulse_len
   // ****************
   // test sequence
   // ****************
   initial begin
      reset = 1'b1;
      bus = '0;
      pwrPins = 4'hF;
      breakSeen = 4'h0;
      consoleSelect = 2'h2;
      haltEnable = 1'b1;
      nodeHalt = 1'b0;
      selfTestIn = 1'b0;
      psTx = 1'b0;
      error_cnt = 0;
      checks_done = 0;
      repeat (5) @(negedge mclk);
      reset = 1'b0;
      chk("fault", {15'h0, backplaneFault}, 16'h0001);
      chk("expander_select", {14'h0, expanderSelect}, 16'h0003);
      chk("rst idle", {15'h0, backplaneReset}, 16'h0000);
      rd(`HPRM_ADDR_MISC, 8'hFF, "misc");
      $display("test reset values done");
      for (int i = 0; i < 32; i++) begin
         pwrPins = i[3:0];
         nodeHalt = i[4];
         repeat (3) @(negedge mclk);
         rd(`HPRM_ADDR_HALT, {2'b00, i[3:1], ~i[0], i[4], 1'b0}, "halt");
      end
      nodeHalt = 1'b0;
      $display("test status bits done");
      breakSeen = 4'h2;
      repeat (3) @(negedge mclk);
      breakSeen = 4'h1;
      repeat (3) @(negedge mclk);
      rd(`HPRM_ADDR_HALT, 8'h38, "other port");
      breakSeen = 4'h0;
      repeat (3) @(negedge mclk);
      chk("break halt", {15'h0, breakHalt}, 16'h0000);
      consoleSelect = 2'h1;
      breakSeen = 4'h2;
      repeat (3) @(negedge mclk);
      breakSeen = 4'h0;
      repeat (3) @(negedge mclk);
      chk("break halt", {15'h0, breakHalt}, 16'h0001);
      haltEnable = 1'b0;
      @(negedge mclk);
      chk("halt disabled", {15'h0, breakHalt}, 16'h0000);
      haltEnable = 1'b1;
      pwrPins.secureN = 1'b0;
      repeat (4) @(negedge mclk);
      chk("secure block", {15'h0, breakHalt}, 16'h0000);
      rd(`HPRM_ADDR_HALT, 8'h7C, "halt sec");
      pwrPins.secureN = 1'b1;
      wr(`HPRM_ADDR_HALT, 8'hBF);
      rd(`HPRM_ADDR_HALT, 8'h78, "no clear");
      wr(`HPRM_ADDR_HALT, 8'h40);
      rd(`HPRM_ADDR_HALT, 8'h38, "w1c");
      $display("test break halt done");
      wr(`HPRM_ADDR_RST, 8'h00);
      pulse_len(n);
      chk("rst len", n[15:0], 16'h0200);
      wr(`HPRM_ADDR_RST, 8'hA5);
      repeat (100) @(negedge mclk);
      wr(`HPRM_ADDR_RST, 8'h00);
      pulse_len(n);
      chk("rst restart", n[15:0], 16'h0200);
      $display("test backplane reset done");
      for (int s = 0; s < 4; s++) begin
         wr(`HPRM_ADDR_MISC, {6'h00, s[1:0]});
         rd(`HPRM_ADDR_MISC, {5'h1F, 1'b0, s[1:0]}, "misc");
         chk("fault", {15'h0, backplaneFault}, 16'h0000);
         for (int t = 0; t < 2; t++) begin
            psTx = t[0];
            @(negedge mclk);
            chk("ps rx", {15'h0, psRx}, {15'h0, (s == 3) ? t[0] : ~t[0]});
            if (s < 3) chk("cab tx", {15'h0, cabinetTx[s]}, {15'h0, t[0]});
         end
      end
      selfTestIn = 1'b1;
      wr(`HPRM_ADDR_MISC, 8'h04);
      chk("fault", {15'h0, backplaneFault}, 16'h0001);
      chk("stp", {15'h0, selfTestPassed}, 16'h0001);
      selfTestIn = 1'b0;
      @(negedge mclk);
      chk("stp", {15'h0, selfTestPassed}, 16'h0000);
      $display("test misc control done");
      rd(`HPRM_ADDR_RMODE, 8'h00, "rmode");
      chk("ignore", {15'h0, forceIgnore}, 16'h0000);
      wr(`HPRM_ADDR_RMODE, 8'h00);
      chk("ignore", {15'h0, forceIgnore}, 16'h0001);
      rd(32'hF7000104, 8'h00, "unmapped");
      $display("test disconnect done");
      results();
   end
endmodule : tb_top
